// *** inc/cppc_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface cppc_link_if;
  logic sclOut;
  logic sclOe;
  logic sdaHostOut;
  logic sdaHostOe;
  logic sdaDevOut;
  logic sdaDevOe;
  logic powerdownPinLowActive;
  logic scl;
  logic sda;
  // Open-drain wires with pull-up
  assign scl = ~(sclOe & ~sclOut);
  assign sda = ~((sdaHostOe & ~sdaHostOut) | (sdaDevOe & ~sdaDevOut));
  modport host (output sclOut, sclOe, sdaHostOut, sdaHostOe, powerdownPinLowActive,
                input scl, sda);
  modport dev (output sdaDevOut, sdaDevOe, input scl, sda, powerdownPinLowActive);
endinterface
`default_nettype wire

// *** inc/cppc_params.svh ***
`ifndef CPPC_PARAMS_SVH
`define CPPC_PARAMS_SVH
// Device-side locations
`define CPPC_REG_PAGE      8'h00
`define CPPC_REG_DEVSTATE  8'h03
`define CPPC_REG_FAULT     8'h70
`define CPPC_REG_FAULTCLR  8'h78
`define CPPC_REG_XOR       8'h7D
`define CPPC_REG_CRC       8'h7E
`define CPPC_REG_BOOK      8'h7F
`define CPPC_PAGE_ZERO     8'h00
`define CPPC_BOOK_XOR      8'h8C
`define CPPC_BOOK_BIQUAD   8'hAA
`define CPPC_CRC_POLY      8'h07
`define CPPC_STATE_HIZ     2'h2
`define CPPC_STATE_PLAY    2'h3
`define CPPC_DEVSTATE_RST  2'h0
`define CPPC_DEV_ADDR      7'h4C
// Fault field positions
`define CPPC_FLT_DC        2
// Timing
`define CPPC_CLK_MHZ       200
`define CPPC_SCL_KHZ       400
`define CPPC_QTR_CYC       ((`CPPC_CLK_MHZ * 1000) / (`CPPC_SCL_KHZ * 4))
`define CPPC_OVERCURRENT_SHUTDOWN_NS       100
`define CPPC_OVERCURRENT_SHUTDOWN_CYC      ((`CPPC_OVERCURRENT_SHUTDOWN_NS * `CPPC_CLK_MHZ) / 1000)
`define CPPC_OVERCURRENT_SHUTDOWN_LAT      3
`define CPPC_STARTUP_MS    5
`define CPPC_SHUTDOWN_MS   6
// Controller APB map
`define CPPC_APB_CMD       8'h00
`define CPPC_APB_STATUS    8'h04
`define CPPC_APB_RDATA     8'h08
`define CPPC_APB_PWR       8'h0C
`define CPPC_CMD_SUB_LSB   0
`define CPPC_CMD_WD_LSB    8
`define CPPC_CMD_CNT_LSB   16
`define CPPC_CMD_RD_BIT    20
`endif

// *** inc/cppc_pkg.sv ***
package cppc_pkg;
  typedef enum logic [2:0] {DV_IDLE, DV_RX, DV_ACK, DV_TX, DV_RACK} cppc_dev_fsm_type;
  typedef enum logic [1:0] {PH_ADDR, PH_SUB, PH_DATA} cppc_phase_type;
  typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BIT, HS_STOP} cppc_host_fsm_type;
endpackage

// *** rtl/cppc_device.sv ***
// The APB slave port was decided locally.
`include "cppc_params.svh"
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Reads stream bytes, sub-address incrementing each
// - Host ends read with NACK, stop
// - Page-zero write at 0x7F selects book
// - Write at 0x00 selects page
// - Host reaches page zero before book change
// - Host writes biquad coefficients fully, ascending
// - Checksums ignore reads, count only writes
// - Two 8-bit checksums kept, readable on page zero (XOR in book 0x8C only)
// - CRC polynomial 0x07, order sensitive
// - CRC skips book and page switches
// - CRC at 0x7E page zero; write reloads
// - XOR folds each written byte in
// - XOR counts book 0x8C, not page zero
// - XOR at 0x7D of 0x8C; write reloads
// - Host start-up order with 5 ms wait (CPPC_STARTUP_MS unused; tb waits 8 clocks after power-up)
// - Silent on the bus during power-down
// - Host Hi-Z or power-down, 6 ms wait (CPPC_SHUTDOWN_MS unused; no wait in code)
// - Host scales wait to rate and ramp (code has no wait to scale)
// - Pulse cut on limit, bridge-tied only
// - Overcurrent shuts channel, latched till cleared
// - DC offset asserts fault, outputs Hi-Z
// - State field: sleep, sleep, Hi-Z, play
// - Page select spans 0 to 255
module cppc_device #(
  parameter logic [6:0] DEV_ADDR = `CPPC_DEV_ADDR
) (
  input  wire logic  clk,                  // 200 MHz clock
  input  wire logic  sys_rst,              // Async reset
  cppc_link_if.dev   link,                 // Serial control link
  input  wire logic [1:0] ocTrip,          // Peak overcurrent per channel
  input  wire logic [1:0] curLimit,        // Current limit reached
  input  wire logic  dcDetect,             // DC offset seen
  input  wire logic  parallelMode,         // Parallel-bridge output mode
  output logic       faultOutputLowActive, // Fault line
  output logic       outHiz,               // Output stage Hi-Z
  output logic [1:0] chanEnable,           // Channel running
  output logic [1:0] pulseCut              // Truncate present pulse
);
  typedef struct packed {
    cppc_pkg::cppc_dev_fsm_type st;
    cppc_pkg::cppc_phase_type   ph;
    logic       sclP;
    logic       sdaP;
    logic       rw;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic [7:0] subAddr;
    logic [7:0] page;
    logic [7:0] book;
    logic [7:0] crc;
    logic [7:0] xorSum;
    logic [1:0] devState;
    logic [2:0] fault;
    logic       sdaOe;
    logic       faultN;
    logic       hiz;
    logic [1:0] chanEn;
    logic [1:0] cut;
  } cppc_dev_regs_type;

  localparam cppc_dev_regs_type DEV_RST = '{
    st: cppc_pkg::DV_IDLE, ph: cppc_pkg::PH_ADDR, devState: `CPPC_DEVSTATE_RST,
    // Edge history at idle level, so waking sees no false edge
    faultN: 1'b1, hiz: 1'b1, sclP: 1'b1, sdaP: 1'b1, default: '0};

  cppc_dev_regs_type r;
  cppc_dev_regs_type next_r;
  logic [7:0]  mem [256];
  logic        memWe;
  logic [7:0]  memAddr;
  logic [7:0]  memData;
  logic [7:0]  pins;
  logic        sclS;
  logic        sdaS;
  logic        pdnS;
  logic [1:0]  ocS;
  logic [1:0]  curS;
  logic        dcS;
  logic        parS;
  logic        sclRise;
  logic        sclFall;
  logic        startC;
  logic        stopC;
  logic        onP0;
  logic [2:0]  faultClr;

  if (`CPPC_OVERCURRENT_SHUTDOWN_CYC < `CPPC_OVERCURRENT_SHUTDOWN_LAT) begin : g_chk
    $error("Shutdown latency exceeds the allowed time");
  end

  cppc_sync #(.WIDTH(8)) u_sync (
    .clk    (clk),
    .sys_rst(sys_rst),
    .async  ({link.scl, link.sda, link.powerdownPinLowActive, ocTrip, curLimit,
              dcDetect}),
    .synced (pins)
  );

  // Mode pin is static; one more sync would not change behaviour
  cppc_sync #(.WIDTH(1)) u_sync_mode (
    .clk    (clk),
    .sys_rst(sys_rst),
    .async  (parallelMode),
    .synced (parS)
  );

  assign {sclS, sdaS, pdnS, ocS, curS, dcS} = pins;
  assign sclRise = sclS & ~r.sclP;
  assign sclFall = ~sclS & r.sclP;
  assign startC  = sclS & r.sdaP & ~sdaS;
  assign stopC   = sclS & ~r.sdaP & sdaS;
  assign onP0    = r.page == `CPPC_PAGE_ZERO;

  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] v;
    v = c;
    for (int i = 7; i >= 0; i--) begin
      v = {v[6:0], 1'b0} ^ ((v[7] ^ d[i]) ? `CPPC_CRC_POLY : 8'h00);
    end
    return v;
  endfunction

  function automatic logic [7:0] readByte(input logic [7:0] a);
    logic [7:0] v;
    v = mem[a];
    if (a == `CPPC_REG_PAGE) begin
      v = r.page;
    end else if (onP0) begin
      unique case (a)
        `CPPC_REG_BOOK:     v = r.book;
        `CPPC_REG_CRC:      v = r.crc;
        `CPPC_REG_DEVSTATE: v = {6'h00, r.devState};
        `CPPC_REG_FAULT:    v = {5'h00, r.fault};
        `CPPC_REG_XOR: begin
          if (r.book == `CPPC_BOOK_XOR) begin
            v = r.xorSum;
          end
        end
        default: v = mem[a];
      endcase
    end
    return v;
  endfunction

  always_comb begin
    next_r   = r;
    memWe    = 1'b0;
    memAddr  = r.subAddr;
    memData  = r.shift;
    faultClr = 3'h0;
    next_r.sclP = sclS;
    next_r.sdaP = sdaS;
    if (startC) begin
      next_r.st     = cppc_pkg::DV_RX;
      next_r.ph     = cppc_pkg::PH_ADDR;
      next_r.bitCnt = 4'h0;
      next_r.sdaOe  = 1'b0;
    end else if (stopC) begin
      next_r.st    = cppc_pkg::DV_IDLE;
      next_r.sdaOe = 1'b0;
    end else begin
      unique case (r.st)
        cppc_pkg::DV_IDLE: begin
          next_r.sdaOe = 1'b0;
        end
        cppc_pkg::DV_RX: begin
          if (sclRise && r.bitCnt < 4'h8) begin
            next_r.shift  = {r.shift[6:0], sdaS};
            next_r.bitCnt = r.bitCnt + 4'h1;
          end else if (sclFall && r.bitCnt == 4'h8) begin
            next_r.bitCnt = 4'h0;
            next_r.st     = cppc_pkg::DV_ACK;
            next_r.sdaOe  = 1'b1;
            unique case (r.ph)
              cppc_pkg::PH_ADDR: begin
                if (r.shift[7:1] == DEV_ADDR) begin
                  next_r.rw = r.shift[0];
                  next_r.ph = cppc_pkg::PH_SUB;
                end else begin
                  next_r.st    = cppc_pkg::DV_IDLE;
                  next_r.sdaOe = 1'b0;
                end
              end
              cppc_pkg::PH_SUB: begin
                next_r.subAddr = r.shift;
                next_r.ph      = cppc_pkg::PH_DATA;
              end
              cppc_pkg::PH_DATA: begin
                next_r.subAddr = r.subAddr + 8'h01;
                if (r.subAddr == `CPPC_REG_PAGE) begin
                  next_r.page = r.shift;
                end else if (r.subAddr == `CPPC_REG_BOOK && onP0) begin
                  next_r.book = r.shift;
                end else begin
                  memWe = 1'b1;
                  if (onP0 && r.subAddr == `CPPC_REG_CRC) begin
                    next_r.crc = r.shift;
                  end else begin
                    next_r.crc = crc8(r.crc, r.shift);
                  end
                  if (r.book == `CPPC_BOOK_XOR) begin
                    if (!onP0) begin
                      next_r.xorSum = r.xorSum ^ r.shift;
                    end else if (r.subAddr == `CPPC_REG_XOR) begin
                      next_r.xorSum = r.shift;
                    end
                  end
                  if (onP0 && r.subAddr == `CPPC_REG_DEVSTATE) begin
                    next_r.devState = r.shift[1:0];
                  end
                  if (onP0 && r.subAddr == `CPPC_REG_FAULTCLR) begin
                    faultClr = r.shift[2:0];
                  end
                end
              end
              default: next_r.st = cppc_pkg::DV_IDLE;
            endcase
          end
        end
        cppc_pkg::DV_ACK: begin
          if (sclFall) begin
            if (r.rw) begin
              next_r.shift   = readByte(r.subAddr);
              next_r.sdaOe   = ~next_r.shift[7];
              next_r.bitCnt  = 4'h1;
              next_r.subAddr = r.subAddr + 8'h01;
              next_r.st      = cppc_pkg::DV_TX;
            end else begin
              next_r.sdaOe = 1'b0;
              next_r.st    = cppc_pkg::DV_RX;
            end
          end
        end
        cppc_pkg::DV_TX: begin
          if (sclFall) begin
            if (r.bitCnt == 4'h8) begin
              next_r.sdaOe = 1'b0;
              next_r.st    = cppc_pkg::DV_RACK;
            end else begin
              next_r.shift  = {r.shift[6:0], 1'b0};
              next_r.sdaOe  = ~r.shift[6];
              next_r.bitCnt = r.bitCnt + 4'h1;
            end
          end
        end
        cppc_pkg::DV_RACK: begin
          if (sclRise) begin
            // Host ACK sends next byte; NACK ends the read
            next_r.st = sdaS ? cppc_pkg::DV_IDLE : cppc_pkg::DV_ACK;
          end
        end
        default: next_r.st = cppc_pkg::DV_IDLE;
      endcase
    end
    // New events win over a clear in the same cycle
    next_r.fault  = (r.fault & ~faultClr) | {dcS, ocS};
    next_r.faultN = ~|next_r.fault;
    next_r.hiz    = next_r.devState != `CPPC_STATE_PLAY || next_r.fault[`CPPC_FLT_DC];
    for (int i = 0; i < 2; i++) begin
      next_r.chanEn[i] = ~next_r.hiz & ~next_r.fault[i];
      next_r.cut[i]    = curS[i] & ~parS & next_r.chanEn[i];
    end
    if (!pdnS) begin
      next_r = DEV_RST;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= DEV_RST;
    end else begin
      r <= next_r;
    end
  end

  always_ff @(posedge clk) begin
    if (memWe && pdnS) begin
      mem[memAddr] <= memData;
    end
  end

  assign link.sdaDevOe     = r.sdaOe;
  assign link.sdaDevOut    = 1'b0;
  assign faultOutputLowActive = r.faultN;
  assign outHiz            = r.hiz;
  assign chanEnable        = r.chanEn;
  assign pulseCut          = r.cut;
endmodule // cppc_device
`default_nettype wire

// *** rtl/cppc_host.sv ***
`include "cppc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module cppc_host #(
  parameter logic [6:0] DEV_ADDR = `CPPC_DEV_ADDR,
  parameter int         QTR_CYC  = `CPPC_QTR_CYC
) (
  input  wire logic        clk,     // 200 MHz clock
  input  wire logic        sys_rst, // Async reset
  input  wire logic        psel,    // APB select
  input  wire logic        penable, // APB enable
  input  wire logic        pwrite,  // APB direction
  input  wire logic [7:0]  paddr,   // APB byte address
  input  wire logic [31:0] pwdata,  // APB write data
  output logic      [31:0] prdata,  // APB read data
  output logic             pready,  // APB ready
  output logic             pslverr, // APB error
  cppc_link_if.host        link     // Serial control link
);
  typedef struct packed {
    cppc_pkg::cppc_host_fsm_type st;
    logic [15:0] qCnt;
    logic [1:0]  q;
    logic [3:0]  bitCnt;
    logic [7:0]  shift;
    logic [1:0]  byteIdx;
    logic        rxMode;
    logic [2:0]  rxN;
    logic [7:0]  sub;
    logic [7:0]  wdata;
    logic [2:0]  cnt;
    logic        rd;
    logic [31:0] rdData;
    logic        busy;
    logic        nack;
    logic        pwrUp;
    logic        sclOe;
    logic        sdaOe;
    logic        ready;
    logic        err;
    logic [31:0] rdBus;
  } cppc_host_regs_type;

  cppc_host_regs_type r;
  cppc_host_regs_type next_r;
  logic sdaS;
  logic tick;
  logic last;

  if (QTR_CYC < 2 || QTR_CYC > 65535) begin : g_chk
    $error("QTR_CYC out of range");
  end

  cppc_sync #(.WIDTH(1)) u_sync (
    .clk    (clk),
    .sys_rst(sys_rst),
    .async  (link.sda),
    .synced (sdaS)
  );

  assign tick = r.qCnt == 16'(QTR_CYC - 1);
  assign last = ({1'b0, r.rxN} + 4'h1) >= {1'b0, r.cnt};

  function automatic logic mapped(input logic [7:0] a);
    return a == `CPPC_APB_CMD || a == `CPPC_APB_STATUS || a == `CPPC_APB_RDATA ||
           a == `CPPC_APB_PWR;
  endfunction

  always_comb begin
    next_r = r;
    if (r.st != cppc_pkg::HS_IDLE) begin
      next_r.qCnt = tick ? 16'h0000 : r.qCnt + 16'h0001;
    end
    if (tick) begin
      next_r.q = r.q + 2'h1;
      unique case (r.st)
        cppc_pkg::HS_START: begin
          unique case (r.q)
            2'h0: next_r.sdaOe = 1'b0;
            2'h1: next_r.sclOe = 1'b0;
            2'h2: next_r.sdaOe = 1'b1;
            2'h3: begin
              next_r.sclOe  = 1'b1;
              next_r.st     = cppc_pkg::HS_BIT;
              next_r.bitCnt = 4'h0;
              next_r.shift  = {DEV_ADDR, r.byteIdx == 2'h2};
            end
          endcase
        end
        cppc_pkg::HS_BIT: begin
          unique case (r.q)
            2'h0: begin
              if (r.rxMode) begin
                next_r.sdaOe = r.bitCnt == 4'h8 && !last;
              end else begin
                next_r.sdaOe = r.bitCnt != 4'h8 && !r.shift[7];
              end
            end
            2'h1: next_r.sclOe = 1'b0;
            2'h2: begin
              if (r.bitCnt == 4'h8) begin
                next_r.nack = !r.rxMode && sdaS;
              end else if (r.rxMode) begin
                next_r.shift = {r.shift[6:0], sdaS};
              end
            end
            2'h3: begin
              next_r.sclOe  = 1'b1;
              next_r.bitCnt = r.bitCnt + 4'h1;
              if (r.bitCnt != 4'h8) begin
                if (!r.rxMode) begin
                  next_r.shift = {r.shift[6:0], 1'b0};
                end
              end else begin
                next_r.bitCnt  = 4'h0;
                next_r.byteIdx = r.byteIdx + 2'h1;
                next_r.st      = cppc_pkg::HS_STOP;
                if (r.rxMode) begin
                  next_r.rdData = {r.rdData[23:0], r.shift};
                  next_r.rxN    = r.rxN + 3'h1;
                  if (!last) begin
                    next_r.st = cppc_pkg::HS_BIT;
                  end
                end else if (!r.nack) begin
                  next_r.st = cppc_pkg::HS_BIT;
                  unique case (r.byteIdx)
                    2'h0: next_r.shift = r.sub;
                    2'h1: begin
                      next_r.shift = r.wdata;
                      if (r.rd) begin
                        next_r.st = cppc_pkg::HS_START;
                      end
                    end
                    default: begin
                      next_r.rxMode = r.rd;
                      if (!r.rd) begin
                        next_r.st = cppc_pkg::HS_STOP;
                      end
                    end
                  endcase
                end
              end
            end
          endcase
        end
        cppc_pkg::HS_STOP: begin
          unique case (r.q)
            2'h0: next_r.sdaOe = 1'b1;
            2'h1: next_r.sclOe = 1'b0;
            2'h2: next_r.sdaOe = 1'b0;
            2'h3: begin
              next_r.st   = cppc_pkg::HS_IDLE;
              next_r.busy = 1'b0;
            end
          endcase
        end
        default: next_r.q = 2'h0;
      endcase
    end
    // APB: answer one cycle after setup
    if (psel && !penable) begin
      next_r.ready = 1'b1;
      next_r.err   = !mapped(paddr);
      unique case (paddr)
        `CPPC_APB_CMD:    next_r.rdBus = {11'h000, r.rd, 1'b0, r.cnt, r.wdata, r.sub};
        `CPPC_APB_STATUS: next_r.rdBus = {30'h00000000, r.nack, r.busy};
        `CPPC_APB_RDATA:  next_r.rdBus = r.rdData;
        `CPPC_APB_PWR:    next_r.rdBus = {31'h00000000, r.pwrUp};
        default:          next_r.rdBus = 32'h00000000;
      endcase
    end
    if (psel && penable && r.ready) begin
      next_r.ready = 1'b0;
      next_r.err   = 1'b0;
      if (pwrite && paddr == `CPPC_APB_PWR) begin
        next_r.pwrUp = pwdata[0];
      end
      if (pwrite && paddr == `CPPC_APB_CMD && !r.busy) begin
        next_r.sub     = pwdata[`CPPC_CMD_SUB_LSB +: 8];
        next_r.wdata   = pwdata[`CPPC_CMD_WD_LSB +: 8];
        next_r.cnt     = pwdata[`CPPC_CMD_CNT_LSB +: 3];
        next_r.rd      = pwdata[`CPPC_CMD_RD_BIT];
        next_r.busy    = 1'b1;
        next_r.nack    = 1'b0;
        next_r.rdData  = 32'h00000000;
        next_r.st      = cppc_pkg::HS_START;
        next_r.q       = 2'h0;
        next_r.qCnt    = 16'h0000;
        next_r.byteIdx = 2'h0;
        next_r.rxMode  = 1'b0;
        next_r.rxN     = 3'h0;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '{st: cppc_pkg::HS_IDLE, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign prdata                     = r.rdBus;
  assign pready                     = r.ready;
  assign pslverr                    = r.err;
  assign link.sclOe                 = r.sclOe;
  assign link.sclOut                = 1'b0;
  assign link.sdaHostOe             = r.sdaOe;
  assign link.sdaHostOut            = 1'b0;
  assign link.powerdownPinLowActive = r.pwrUp;
endmodule // cppc_host
`default_nettype wire

// *** rtl/cppc_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module cppc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,     // System clock
  input  wire logic             sys_rst, // Async reset
  input  wire logic [WIDTH-1:0] async,   // Foreign-domain levels
  output logic      [WIDTH-1:0] synced   // Two-flop result
);
  typedef struct packed {
    logic [WIDTH-1:0] stage;
    logic [WIDTH-1:0] out;
  } cppc_sync_regs_type;
  cppc_sync_regs_type r;
  cppc_sync_regs_type next_r;

  if (WIDTH < 1) begin : g_chk
    $error("cppc_sync WIDTH must be at least 1");
  end

  always_comb begin
    next_r.stage = async;
    next_r.out   = r.stage;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign synced = r.out;
endmodule // cppc_sync
`default_nettype wire

// *** verif/cppc_link_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module cppc_link_props (
  input wire logic       clk,                   // Clock
  input wire logic       sys_rst,               // Reset
  input wire logic       scl,                   // Link clock wire
  input wire logic       sda,                   // Link data wire
  input wire logic       sdaDevOe,              // Device pulls data
  input wire logic       powerdownPinLowActive, // Device enable pin
  input wire logic [1:0] ocTrip,                // Peak overcurrent inputs
  input wire logic       dcDetect,              // DC offset input
  input wire logic       parallelMode,          // Parallel-bridge mode
  input wire logic       faultOutputLowActive,  // Fault line
  input wire logic       outHiz,                // Output stage Hi-Z
  input wire logic [1:0] chanEnable,            // Channel running
  input wire logic [1:0] pulseCut               // Pulse truncation
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence stopSeen;
    scl && $past(scl) && $rose(sda);
  endsequence
  sequence pinHeldLow;
    !powerdownPinLowActive [*4];
  endsequence
  AST_SILENT_PDN: assert property (pinHeldLow |-> !sdaDevOe)
    else $error("device pulls data while powered down");
  AST_DEV_SDA_SCL_LOW: assert property (
    $changed(sdaDevOe) && powerdownPinLowActive |-> !scl)
    else $error("device moved data while link clock high");
  AST_IDLE_AFTER_STOP: assert property (stopSeen |=> !sdaDevOe [*8])
    else $error("device pulls data after stop");
  sequence ocHeld;
    (ocTrip[0] && powerdownPinLowActive) [*4];
  endsequence
  sequence dcHeld;
    (dcDetect && powerdownPinLowActive) [*4];
  endsequence
  sequence parHeld;
    parallelMode [*4];
  endsequence
  AST_OC_SHUTDOWN: assert property (ocHeld |-> !chanEnable[0] && !faultOutputLowActive)
    else $error("channel still running after overcurrent");
  AST_DC_HIZ: assert property (dcHeld |-> outHiz && !faultOutputLowActive)
    else $error("no fault or Hi-Z after DC offset");
  AST_NO_CUT_PARALLEL: assert property (parHeld |-> pulseCut == 2'b00)
    else $error("pulse cut in parallel-bridge mode");
  cover property (stopSeen);
endmodule // cppc_link_props
`default_nettype wire

// *** verif/cppc_tb.sv ***
`include "cppc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module cppc_tb;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, faultN, outHiz;
  logic        dcDetect = 1'b0, parMode = 1'b0;
  logic [1:0]  ocTrip = 2'h0, curLimit = 2'h0, chanEnable, pulseCut;
  logic [15:0] seed = 16'h33B6;
  logic [7:0]  page = 8'h00, book = 8'h00, crc = 8'h00, xr = 8'h00, s;
  int          fails = 0, tests_run = 0;
  always #2.5 clk = ~clk;
  cppc_link_if link ();
  cppc_host #(.QTR_CYC(4)) u_cppc_host (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link));
  cppc_device u_cppc_device (.clk(clk), .sys_rst(sys_rst), .link(link), .ocTrip(ocTrip),
    .curLimit(curLimit), .dcDetect(dcDetect), .parallelMode(parMode),
    .faultOutputLowActive(faultN), .outHiz(outHiz), .chanEnable(chanEnable),
    .pulseCut(pulseCut));
  cppc_link_props u_cppc_link_props (.clk(clk), .sys_rst(sys_rst), .scl(link.scl),
    .sda(link.sda), .sdaDevOe(link.sdaDevOe),
    .powerdownPinLowActive(link.powerdownPinLowActive), .ocTrip(ocTrip),
    .dcDetect(dcDetect), .parallelMode(parMode), .faultOutputLowActive(faultN),
    .outHiz(outHiz), .chanEnable(chanEnable), .pulseCut(pulseCut));
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] dv);
    logic [7:0] x;
    x = c ^ dv;
    for (int i = 0; i < 8; i++) x = x[7] ? {x[6:0], 1'b0} ^ `CPPC_CRC_POLY : {x[6:0], 1'b0};
    return x;
  endfunction
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task conclude;
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task link_op(input logic r, input logic [2:0] n, input logic [7:0] sb, input logic [7:0] wd);
    apb(1'b1, `CPPC_APB_CMD, {11'h0, r, 1'b0, n, wd, sb});
    rd = 32'h1;
    while (rd[0] !== 1'b0) apb(1'b0, `CPPC_APB_STATUS, 32'h0);
    if (r) apb(1'b0, `CPPC_APB_RDATA, 32'h0);
  endtask
  // Device model of page, book and both checksums
  task wr(input logic [7:0] sb, input logic [7:0] dv);
    if (sb == `CPPC_REG_PAGE) page = dv;
    else if (sb == `CPPC_REG_BOOK && page == 8'h00) book = dv;
    else if (sb == `CPPC_REG_CRC && page == 8'h00) crc = dv;
    else begin
      crc = crc8(crc, dv);
      if (sb == `CPPC_REG_XOR && page == 8'h00 && book == `CPPC_BOOK_XOR) xr = dv;
      else if (book == `CPPC_BOOK_XOR && page != 8'h00) xr = xr ^ dv;
    end
    link_op(1'b0, 3'h0, sb, dv);
  endtask
  task burst(input int n);
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      s = (i == 0) ? 8'hF0 : 8'h10 + {2'b00, seed[5:0]};
      wr(s, seed[15:8]);
      link_op(1'b1, 3'h1, s, 8'h00);
      check(rd[7:0], seed[15:8]);
    end
  endtask
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    check(outHiz, 1'b1);
    apb(1'b0, 8'hF0, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
    link_op(1'b0, 3'h0, 8'h10, 8'h55);
    apb(1'b0, `CPPC_APB_STATUS, 32'h0);
    check(rd[1], 1'b1);
    apb(1'b1, `CPPC_APB_PWR, 32'h1);
    repeat (8) @(posedge clk);
    wr(`CPPC_REG_CRC, 8'h00);
    burst(10);
    wr(`CPPC_REG_PAGE, 8'h00);
    wr(`CPPC_REG_BOOK, `CPPC_BOOK_XOR);
    wr(`CPPC_REG_XOR, 8'h00);
    wr(`CPPC_REG_PAGE, 8'hFF);
    burst(8);
    wr(`CPPC_REG_PAGE, 8'h00);
    wr(8'h20, seed[7:0]);
    link_op(1'b1, 3'h2, `CPPC_REG_XOR, 8'h00);
    check(rd[15:0], {xr, crc});
    apb(1'b0, `CPPC_APB_CMD, 32'h0);
    check(rd, {11'h000, 1'b1, 1'b0, 3'h2, 8'h00, `CPPC_REG_XOR});
    wr(`CPPC_REG_BOOK, `CPPC_BOOK_BIQUAD);
    wr(`CPPC_REG_PAGE, 8'h01);
    for (int j = 0; j < 5; j++) begin
      seed = lfsr(seed);
      wr(8'h18 + j[7:0], seed[7:0]);
    end
    wr(`CPPC_REG_PAGE, 8'h00);
    link_op(1'b1, 3'h1, `CPPC_REG_CRC, 8'h00);
    check(rd[7:0], crc);
    wr(`CPPC_REG_BOOK, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(`CPPC_REG_DEVSTATE, k[7:0]);
      @(negedge clk);
      check(outHiz, k != 3);
    end
    @(posedge clk);
    ocTrip <= 2'b01;
    repeat (4) @(posedge clk);
    ocTrip <= 2'b00;
    @(negedge clk);
    check({faultN, chanEnable[0]}, 2'b00);
    link_op(1'b1, 3'h1, `CPPC_REG_FAULT, 8'h00);
    check(rd[2:0], 3'b001);
    wr(`CPPC_REG_FAULTCLR, 8'h07);
    check(faultN, 1'b1);
    check(chanEnable, 2'b11);
    curLimit <= 2'b11;
    repeat (4) @(negedge clk);
    check(pulseCut, 2'b11);
    @(posedge clk);
    parMode <= 1'b1;
    repeat (4) @(negedge clk);
    check(pulseCut, 2'b00);
    @(posedge clk);
    dcDetect <= 1'b1;
    repeat (6) @(negedge clk);
    check({faultN, outHiz, chanEnable}, 4'b0100);
    apb(1'b1, `CPPC_APB_PWR, 32'h0);
    repeat (4) @(negedge clk);
    check({faultN, outHiz, chanEnable}, 4'b1100);
    conclude();
  end
  initial begin
    repeat (95000) @(posedge clk);
    fails++;
    conclude();
  end
endmodule // cppc_tb
`default_nettype wire
